/* design/mdc_dac_control.sv */
// Register and control logic of the quad or octal dual-stage converter, serial and parallel loading.
//
// Contract
// - Global standby one idles all channels, reference stays
// - Global soft clear forces main registers to clear code
// - Soft clear leaves offset registers untouched
// - Address decode: quad ignores top bit
// - Channel sleep bit low idles that channel
// - Channel clear affects only addressed main register
// - Channel clear acts on next load strobe
// - Two bits pick the bias source
// - Word top bit picks main or offset
// - Offset register eight bits, two LSBs ignored
// - Offset coding follows main coding
// - Power-up comes up in standby
// - Global defaults: power on, standby set
// - Channel defaults: sleep_n 1, clear 1, bias 0
// - Parallel write captured on chip select and strobe
// - Mode pin high data, low control
// - Bus select bit picks global or channel
// - Parallel data routed by stored route bit
// - Code outputs update on load strobe, soft clear or clear pin
// - Clear pin sets main registers to clear code
// - Clear pin sets offset registers to midscale
// - Shift on falling clock edge, MSB first
// - Bits 14 and 13 select register group
// - Coding bit: 0 twos complement, 1 binary
// - Power-down bit low idles everything, keeps registers
module mdc_dac_control #(
  parameter bit OCTAL = 1'b1
) (
  // System clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Serial link, clocked by the host.
  input wire logic i_shift_clock,
  input wire logic i_frame_sync_n,
  input wire logic i_serial_data_in,
  // Parallel write bus.
  input wire mdc_pkg::mdc_par_pins_t i_par,
  // Asynchronous strobes.
  input wire logic i_load_outputs_n,
  input wire logic i_clear_n,
  // Converter controls.
  output mdc_pkg::mdc_chan_out_t [mdc_pkg::CH_COUNT-1:0] o_channels,
  output logic o_ref_enable,
  output logic o_coding_select
);

  localparam int N = mdc_pkg::CH_COUNT;

  function automatic logic [2:0] decode_channel(input logic [2:0] addr);
    decode_channel = OCTAL ? addr : {1'h0, addr[1:0]};
  endfunction

  function automatic logic [mdc_pkg::MAIN_BITS-1:0] main_clear_code(input logic binary);
    main_clear_code = binary ? mdc_pkg::MAIN_CLEAR_BINARY : mdc_pkg::MAIN_CLEAR_TWOS;
  endfunction

  function automatic logic [mdc_pkg::SUB_BITS-1:0] sub_mid_code(input logic binary);
    sub_mid_code = binary ? mdc_pkg::SUB_MID_BINARY : mdc_pkg::SUB_MID_TWOS;
  endfunction

  // ---------------- Link domain: serial shifter ----------------
  logic [mdc_pkg::WORD_BITS-2:0] shift_reg;
  logic [mdc_pkg::WORD_BITS-2:0] next_shift_reg;
  logic [3:0] bit_count;
  logic [3:0] next_bit_count;
  logic [mdc_pkg::WORD_BITS-1:0] word;
  logic [mdc_pkg::WORD_BITS-1:0] next_word;
  logic word_toggle;
  logic next_word_toggle;

  always_comb begin
    next_shift_reg = {shift_reg[mdc_pkg::WORD_BITS-3:0], i_serial_data_in};
    next_word = word;
    next_word_toggle = word_toggle;
    next_bit_count = bit_count + 4'h1;
    if (bit_count == mdc_pkg::LAST_BIT_INDEX) begin
      next_word = {shift_reg, i_serial_data_in};
      next_word_toggle = ~word_toggle;
      next_bit_count = 4'h0;
    end
  end

  // The counter is cleared by the frame signal itself, so an aborted frame cannot leak into the next one
  // even when the host stops its clock between frames.
  always_ff @(negedge i_shift_clock or negedge i_rst_n or posedge i_frame_sync_n) begin
    if (!i_rst_n) begin
      bit_count <= 4'h0;
    end else if (i_frame_sync_n) begin
      bit_count <= 4'h0;
    end else begin
      bit_count <= next_bit_count;
    end
  end

  always_ff @(negedge i_shift_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_reg <= '0;
      word <= '0;
      word_toggle <= 1'h0;
    end else if (!i_frame_sync_n) begin
      shift_reg <= next_shift_reg;
      word <= next_word;
      word_toggle <= next_word_toggle;
    end
  end

  // ---------------- Crossings and pin synchronisers ----------------
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic ld_s1;
  logic ld_s2;
  logic ld_s3;
  logic clr_s1;
  logic clr_s2;
  mdc_pkg::mdc_par_pins_t par_s1;
  mdc_pkg::mdc_par_pins_t par_s2;
  mdc_pkg::mdc_par_pins_t par_hold;
  mdc_pkg::mdc_par_pins_t next_par_hold;
  logic par_active_d;
  logic par_active;

  assign par_active = ~par_s2.cs_n & ~par_s2.wr_n;

  always_comb begin
    next_par_hold = par_active ? par_s2 : par_hold;
  end

  // The serial word register is only read after its toggle has crossed, by which time it has
  // been stable for two system clocks; the host cannot finish another frame that fast.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tog_s1 <= 1'h0;
      tog_s2 <= 1'h0;
      tog_s3 <= 1'h0;
      ld_s1 <= 1'h1;
      ld_s2 <= 1'h1;
      ld_s3 <= 1'h1;
      clr_s1 <= 1'h1;
      clr_s2 <= 1'h1;
      par_s1 <= '{cs_n: 1'h1, wr_n: 1'h1, default: '0};
      par_s2 <= '{cs_n: 1'h1, wr_n: 1'h1, default: '0};
      par_hold <= '{cs_n: 1'h1, wr_n: 1'h1, default: '0};
      par_active_d <= 1'h0;
    end else begin
      tog_s1 <= word_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      ld_s1 <= i_load_outputs_n;
      ld_s2 <= ld_s1;
      ld_s3 <= ld_s2;
      clr_s1 <= i_clear_n;
      clr_s2 <= clr_s1;
      par_s1 <= i_par;
      par_s2 <= par_s1;
      par_hold <= next_par_hold;
      par_active_d <= par_active;
    end
  end

  logic serial_done;
  logic par_done;
  logic load_pulse;
  logic hw_clear;

  assign serial_done = tog_s2 ^ tog_s3;
  assign par_done = par_active_d & ~par_active;
  assign load_pulse = ld_s3 & ~ld_s2;
  assign hw_clear = ~clr_s2;

  // ---------------- Register state ----------------
  logic power_off_n;
  logic next_power_off_n;
  logic standby;
  logic next_standby;
  logic soft_clear;
  logic next_soft_clear;
  logic coding;
  logic next_coding;
  logic sleep_n [N];
  logic next_sleep_n [N];
  logic clear_req [N];
  logic next_clear_req [N];
  logic route_sub [N];
  logic next_route_sub [N];
  mdc_pkg::mdc_bias_t bias [N];
  mdc_pkg::mdc_bias_t next_bias [N];
  logic [mdc_pkg::MAIN_BITS-1:0] main_data [N];
  logic [mdc_pkg::MAIN_BITS-1:0] next_main_data [N];
  logic [mdc_pkg::MAIN_BITS-1:0] main_out [N];
  logic [mdc_pkg::MAIN_BITS-1:0] next_main_out [N];
  logic [mdc_pkg::SUB_BITS-1:0] sub_data [N];
  logic [mdc_pkg::SUB_BITS-1:0] next_sub_data [N];
  logic [mdc_pkg::SUB_BITS-1:0] sub_out [N];
  logic [mdc_pkg::SUB_BITS-1:0] next_sub_out [N];
  logic active [N];
  logic next_active [N];
  mdc_pkg::mdc_cmd_t cmd;

  // Command decode. Serial wins if both interfaces finish in the same cycle; a real part has only one.
  always_comb begin
    cmd = '{target: mdc_pkg::TGT_SYS, default: '0};
    if (serial_done) begin
      cmd.valid = 1'h1;
      cmd.chan = decode_channel(word[mdc_pkg::BIT_ADDR_MSB:mdc_pkg::BIT_ADDR_LSB]);
      cmd.payload = word[mdc_pkg::MAIN_BITS-1:0];
      if (word[mdc_pkg::BIT_SEL_HI]) begin
        cmd.target = word[mdc_pkg::BIT_ROUTE] ? mdc_pkg::TGT_SUB : mdc_pkg::TGT_MAIN;
      end else if (word[mdc_pkg::BIT_SEL_LO]) begin
        cmd.target = mdc_pkg::TGT_CHAN;
      end else begin
        cmd.target = mdc_pkg::TGT_SYS;
      end
    end else if (par_done) begin
      cmd.valid = 1'h1;
      cmd.parallel = 1'h1;
      cmd.chan = decode_channel(par_hold.addr);
      cmd.payload = par_hold.data;
      if (par_hold.mode) begin
        cmd.target = route_sub[cmd.chan] ? mdc_pkg::TGT_SUB : mdc_pkg::TGT_MAIN;
      end else if (par_hold.data[mdc_pkg::PAR_SEL_BIT]) begin
        cmd.target = mdc_pkg::TGT_CHAN;
      end else begin
        cmd.target = mdc_pkg::TGT_SYS;
      end
    end
  end

  always_comb begin
    logic hit;
    hit = 1'h0;
    next_power_off_n = power_off_n;
    next_standby = standby;
    next_soft_clear = soft_clear;
    next_coding = coding;
    if (cmd.valid && cmd.target == mdc_pkg::TGT_SYS) begin
      next_power_off_n = cmd.payload[mdc_pkg::SYS_POWER];
      next_standby = cmd.payload[mdc_pkg::SYS_STANDBY];
      next_soft_clear = cmd.payload[mdc_pkg::SYS_CLEAR];
      next_coding = cmd.payload[mdc_pkg::SYS_CODING];
    end
    for (int i = 0; i < N; i++) begin
      hit = cmd.valid && (cmd.chan == 3'(i));
      next_sleep_n[i] = sleep_n[i];
      next_clear_req[i] = clear_req[i];
      next_route_sub[i] = route_sub[i];
      next_bias[i] = bias[i];
      next_main_data[i] = main_data[i];
      next_main_out[i] = main_out[i];
      next_sub_data[i] = sub_data[i];
      next_sub_out[i] = sub_out[i];
      if (hit && cmd.target == mdc_pkg::TGT_CHAN) begin
        next_sleep_n[i] = cmd.payload[mdc_pkg::CH_SLEEP];
        next_clear_req[i] = cmd.payload[mdc_pkg::CH_CLEAR];
        next_bias[i] = mdc_pkg::mdc_bias_t'(cmd.payload[mdc_pkg::CH_BIAS_HI:mdc_pkg::CH_BIAS_LO]);
        if (cmd.parallel) begin
          next_route_sub[i] = cmd.payload[mdc_pkg::CH_ROUTE];
        end
      end
      if (hit && cmd.target == mdc_pkg::TGT_MAIN) begin
        next_main_data[i] = cmd.payload;
      end
      if (hit && cmd.target == mdc_pkg::TGT_SUB) begin
        next_sub_data[i] = cmd.payload[mdc_pkg::MAIN_BITS-1:mdc_pkg::SUB_LSB];
      end
      if (load_pulse) begin
        next_sub_out[i] = next_sub_data[i];
        if (clear_req[i]) begin
          next_main_data[i] = main_clear_code(coding);
          next_main_out[i] = main_clear_code(coding);
        end else begin
          next_main_out[i] = next_main_data[i];
        end
      end
      // The global soft clear holds the main stage only; the offset stage is left as it was.
      if (soft_clear) begin
        next_main_data[i] = main_clear_code(coding);
        next_main_out[i] = main_clear_code(coding);
      end
      if (hw_clear) begin
        next_main_data[i] = main_clear_code(coding);
        next_main_out[i] = main_clear_code(coding);
        next_sub_data[i] = sub_mid_code(coding);
        next_sub_out[i] = sub_mid_code(coding);
      end
      // Power-down and standby only idle the analog side; register contents survive both.
      next_active[i] = next_power_off_n & ~next_standby & next_sleep_n[i];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      power_off_n <= mdc_pkg::RST_POWER_OFF_N;
      standby <= mdc_pkg::RST_STANDBY;
      soft_clear <= mdc_pkg::RST_SOFT_CLEAR;
      coding <= mdc_pkg::RST_CODING;
      for (int i = 0; i < N; i++) begin
        sleep_n[i] <= mdc_pkg::RST_SLEEP_N;
        clear_req[i] <= mdc_pkg::RST_CLEAR_REQ;
        route_sub[i] <= mdc_pkg::RST_ROUTE;
        bias[i] <= mdc_pkg::BIAS_HALF_SUPPLY;
        main_data[i] <= mdc_pkg::RST_MAIN;
        main_out[i] <= mdc_pkg::RST_MAIN;
        sub_data[i] <= mdc_pkg::RST_SUB;
        sub_out[i] <= mdc_pkg::RST_SUB;
        active[i] <= 1'h0;
      end
    end else begin
      power_off_n <= next_power_off_n;
      standby <= next_standby;
      soft_clear <= next_soft_clear;
      coding <= next_coding;
      for (int i = 0; i < N; i++) begin
        sleep_n[i] <= next_sleep_n[i];
        clear_req[i] <= next_clear_req[i];
        route_sub[i] <= next_route_sub[i];
        bias[i] <= next_bias[i];
        main_data[i] <= next_main_data[i];
        main_out[i] <= next_main_out[i];
        sub_data[i] <= next_sub_data[i];
        sub_out[i] <= next_sub_out[i];
        active[i] <= next_active[i];
      end
    end
  end

  // ---------------- Outputs ----------------
  for (genvar g = 0; g < N; g++) begin : g_out
    assign o_channels[g].active = active[g];
    assign o_channels[g].bias = bias[g];
    assign o_channels[g].main_code = main_out[g];
    assign o_channels[g].offset_code = sub_out[g];
  end

  assign o_ref_enable = power_off_n;
  assign o_coding_select = coding;

endmodule

/* design/mdc_pkg.sv */
// Shared constants, encodings and carrier types of the multichannel converter control block.
package mdc_pkg;

  localparam int CH_COUNT = 8;
  localparam int WORD_BITS = 16;
  localparam int MAIN_BITS = 10;
  localparam int SUB_BITS = 8;

  // Serial word field positions.
  localparam int BIT_ROUTE = 15;
  localparam int BIT_SEL_LO = 14;
  localparam int BIT_SEL_HI = 13;
  localparam int BIT_ADDR_MSB = 12;
  localparam int BIT_ADDR_LSB = 10;
  localparam int SUB_LSB = 2;
  localparam logic [3:0] LAST_BIT_INDEX = 4'hF;

  // Payload field positions, common to serial words and the parallel bus.
  localparam int SYS_CODING = 6;
  localparam int SYS_POWER = 5;
  localparam int SYS_STANDBY = 4;
  localparam int SYS_CLEAR = 3;
  localparam int CH_BIAS_HI = 9;
  localparam int CH_BIAS_LO = 8;
  localparam int CH_ROUTE = 7;
  localparam int CH_SLEEP = 4;
  localparam int CH_CLEAR = 3;
  localparam int PAR_SEL_BIT = 0;

  // Values after reset.
  localparam logic RST_POWER_OFF_N = 1'h1;
  localparam logic RST_STANDBY = 1'h1;
  localparam logic RST_SOFT_CLEAR = 1'h0;
  localparam logic RST_CODING = 1'h0;
  localparam logic RST_SLEEP_N = 1'h1;
  localparam logic RST_CLEAR_REQ = 1'h1;
  localparam logic RST_ROUTE = 1'h0;
  localparam logic [MAIN_BITS-1:0] RST_MAIN = 10'h000;
  localparam logic [SUB_BITS-1:0] RST_SUB = 8'h00;

  // Main clear codes: bottom of range for offset binary, midscale for twos complement; offset codes midscale in both.
  localparam logic [MAIN_BITS-1:0] MAIN_CLEAR_BINARY = 10'h000;
  localparam logic [MAIN_BITS-1:0] MAIN_CLEAR_TWOS = 10'h000;
  localparam logic [SUB_BITS-1:0] SUB_MID_BINARY = 8'h80;
  localparam logic [SUB_BITS-1:0] SUB_MID_TWOS = 8'h00;

  typedef enum logic [1:0] {
    BIAS_HALF_SUPPLY = 2'h0,
    BIAS_INT_REF = 2'h1,
    BIAS_EXT_REF = 2'h2,
    BIAS_UNDEFINED = 2'h3
  } mdc_bias_t;

  typedef enum logic [3:0] {
    TGT_SYS = 4'h1,
    TGT_CHAN = 4'h2,
    TGT_MAIN = 4'h4,
    TGT_SUB = 4'h8
  } mdc_target_t;

  typedef struct packed {
    logic valid;
    logic parallel;
    mdc_target_t target;
    logic [2:0] chan;
    logic [MAIN_BITS-1:0] payload;
  } mdc_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic mode;
    logic [2:0] addr;
    logic [MAIN_BITS-1:0] data;
  } mdc_par_pins_t;

  typedef struct packed {
    logic active;
    mdc_bias_t bias;
    logic [MAIN_BITS-1:0] main_code;
    logic [SUB_BITS-1:0] offset_code;
  } mdc_chan_out_t;

endpackage

/* verif/mdc_dac_control_monitor.sv */
// Port-level checker of the converter control block.
module mdc_dac_control_monitor #(
  parameter bit OCTAL = 1'b1
) (
  // Clock, reset and inputs.
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_shift_clock,
  input wire logic i_frame_sync_n,
  input wire logic i_serial_data_in,
  input wire mdc_pkg::mdc_par_pins_t i_par,
  input wire logic i_load_outputs_n,
  input wire logic i_clear_n,
  // Outputs.
  input wire mdc_pkg::mdc_chan_out_t [mdc_pkg::CH_COUNT-1:0] o_channels,
  input wire logic o_ref_enable,
  input wire logic o_coding_select
);
  logic [3:0] since_ld, since_clr, since_wr, next_since_ld, next_since_clr, next_since_wr;
  logic [mdc_pkg::CH_COUNT-1:0][9:0] mains;
  logic [mdc_pkg::CH_COUNT-1:0][7:0] offs;
  logic [mdc_pkg::CH_COUNT-1:0][2:0] ctls;
  logic any_on, main_clr, off_mid;
  // Saturating ages of the last load, clear and write; outputs may only move shortly after one.
  always_comb begin
    next_since_ld = !i_load_outputs_n ? 4'h0 : since_ld + {3'h0, since_ld != 4'hF};
    next_since_clr = !i_clear_n ? 4'h0 : since_clr + {3'h0, since_clr != 4'hF};
    next_since_wr = (!i_frame_sync_n || !i_par.cs_n) ? 4'h0 : since_wr + {3'h0, since_wr != 4'hF};
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      since_ld <= 4'hF;
      since_clr <= 4'hF;
      since_wr <= 4'hF;
    end else begin
      since_ld <= next_since_ld;
      since_clr <= next_since_clr;
      since_wr <= next_since_wr;
    end
  end
  always_comb begin
    any_on = 1'b0;
    main_clr = 1'b1;
    off_mid = 1'b1;
    for (int k = 0; k < mdc_pkg::CH_COUNT; k++) begin
      mains[k] = o_channels[k].main_code;
      offs[k] = o_channels[k].offset_code;
      ctls[k] = {o_channels[k].active, o_channels[k].bias};
      any_on = any_on | o_channels[k].active;
      main_clr = main_clr & (mains[k] == (o_coding_select ? mdc_pkg::MAIN_CLEAR_BINARY : mdc_pkg::MAIN_CLEAR_TWOS));
      off_mid = off_mid & (offs[k] == (o_coding_select ? mdc_pkg::SUB_MID_BINARY : mdc_pkg::SUB_MID_TWOS));
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_reset_defaults: assert property ($rose(i_rst_n) |-> o_ref_enable && !o_coding_select && !any_on && main_clr)
    else $error("outputs not at power-up values");
  a_hw_clear_main: assert property (!i_clear_n [*6] |-> main_clr)
    else $error("hardware clear left a main code");
  a_hw_clear_offset: assert property (!i_clear_n [*6] |-> off_mid)
    else $error("hardware clear left an offset code");
  a_power_idles: assert property (!o_ref_enable [*2] |-> !any_on)
    else $error("channel active while powered down");
  a_ctrl_from_write: assert property (!$stable({ctls, o_ref_enable, o_coding_select}) |-> since_wr < 4'h9)
    else $error("control outputs moved without a write");
  a_main_cause: assert property (!$stable(mains) |-> since_ld < 4'h8 || since_clr < 4'h8 || since_wr < 4'h9)
    else $error("main code moved without load or clear");
  a_offset_cause: assert property (!$stable(offs) |-> since_ld < 4'h8 || since_clr < 4'h8)
    else $error("offset code moved without load or clear");
  a_quiet_stable: assert property (since_ld > 4'h8 && since_clr > 4'h8 && since_wr > 4'h8 |-> $stable(o_channels))
    else $error("outputs moved while idle");
endmodule

/* verif/mdc_host_model.sv */
// Host-side serial link model that frames words onto the converter link.
module mdc_host_model (
  // Serial link outputs.
  output logic o_shift_clock,
  output logic o_frame_sync_n,
  output logic o_serial_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_shift_clock = 1'b1;
    o_frame_sync_n = 1'b1;
    o_serial_data_in = 1'b0;
  end
  // Sends the top nbits of a word MSB first; fewer than sixteen aborts the frame.
  // The clock stands high between frames and the data line flips once released.
  task automatic send(input logic [15:0] word, input int nbits);
    #23 o_frame_sync_n = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      o_serial_data_in = word[i];
      #80 o_shift_clock = 1'b0;
      #80 o_shift_clock = 1'b1;
    end
    #40 o_frame_sync_n = 1'b1;
    o_serial_data_in = ~o_serial_data_in;
  endtask
endmodule

/* verif/tb.sv */
// Self-checking testbench of the multichannel converter control block.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b1;
  logic load_n = 1'b1;
  logic clear_n = 1'b1;
  mdc_pkg::mdc_par_pins_t par = '{1'b1, 1'b1, 1'b0, 3'h0, 10'h000};
  wire logic sclk;
  wire logic fsync_n;
  wire logic sdata;
  mdc_pkg::mdc_chan_out_t [mdc_pkg::CH_COUNT-1:0] ch;
  logic ref_en;
  logic coding;
  int fails = 0;
  int checks_done = 0;
  mdc_host_model i_mdc_host_model (.o_shift_clock(sclk), .o_frame_sync_n(fsync_n), .o_serial_data_in(sdata));
  mdc_dac_control #(.OCTAL(1'b1)) i_mdc_dac_control (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_shift_clock(sclk),
    .i_frame_sync_n(fsync_n), .i_serial_data_in(sdata), .i_par(par), .i_load_outputs_n(load_n),
    .i_clear_n(clear_n), .o_channels(ch), .o_ref_enable(ref_en), .o_coding_select(coding));
  initial forever #5 i_clock = ~i_clock;
  task automatic chk(input logic [9:0] exp, input logic [9:0] act);
    checks_done++;
    if (exp !== act) begin
      $display("BAD t=%0t exp=%0h got=%0h", $time, exp, act);
      fails++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic ser(input logic [15:0] w);
    i_mdc_host_model.send(w, 16);
    tick(8);
  endtask
  task automatic strobe_load();
    tick(1);
    load_n = 1'b0;
    tick(4);
    load_n = 1'b1;
    tick(6);
  endtask
  task automatic pwr(input logic md, input logic [2:0] a, input logic [9:0] d);
    tick(1);
    par = '{1'b0, 1'b0, md, a, d};
    tick(4);
    par.cs_n = 1'b1;
    par.wr_n = 1'b1;
    tick(8);
  endtask
  task automatic act_all(input logic v);
    for (int k = 0; k < mdc_pkg::CH_COUNT; k++) chk({9'h0, v}, {9'h0, ch[k].active});
  endtask
  task automatic t_global();
    act_all(1'b0);
    chk(10'h1, {9'h0, ref_en});
    chk(10'h0, {8'h0, ch[7].bias});
    ser(16'h0060);
    chk(10'h1, {9'h0, coding});
    act_all(1'b1);
    ser(16'h0070);
    act_all(1'b0);
    ser(16'h0040);
    chk(10'h0, {9'h0, ref_en});
    act_all(1'b0);
    ser(16'h0060);
    act_all(1'b1);
  endtask
  task automatic t_channel();
    ser(16'h5600);
    chk(10'h0, {9'h0, ch[5].active});
    chk(10'h2, {8'h0, ch[5].bias});
    chk(10'h1, {9'h0, ch[4].active});
    for (int b = 0; b < 4; b++) begin
      ser(16'h4810 | 16'(b << 8));
      chk(10'(b), {8'h0, ch[2].bias});
    end
  endtask
  task automatic t_data();
    ser(16'h4D10);
    ser(16'h2D55);
    ser(16'hAE97);
    chk(10'h0, ch[3].main_code);
    strobe_load();
    chk(10'h155, ch[3].main_code);
    chk(10'hA5, {2'h0, ch[3].offset_code});
    i_mdc_host_model.send(16'h2FFF, 10);
    tick(8);
    strobe_load();
    chk(10'h155, ch[3].main_code);
    ser(16'h4D18);
    chk(10'h155, ch[3].main_code);
    strobe_load();
    chk(10'h0, ch[3].main_code);
    chk(10'hA5, {2'h0, ch[3].offset_code});
    ser(16'h4D10);
    ser(16'h2CAA);
    ser(16'h0068);
    strobe_load();
    chk(10'h0, ch[3].main_code);
    chk(10'hA5, {2'h0, ch[3].offset_code});
    ser(16'h0060);
    clear_n = 1'b0;
    tick(10);
    chk(10'h0, ch[3].main_code);
    chk(10'h80, {2'h0, ch[3].offset_code});
    clear_n = 1'b1;
    tick(6);
  endtask
  task automatic t_parallel();
    pwr(1'b0, 3'h6, 10'h191);
    chk(10'h1, {8'h0, ch[6].bias});
    pwr(1'b1, 3'h6, 10'h3C4);
    strobe_load();
    chk(10'hF1, {2'h0, ch[6].offset_code});
    pwr(1'b0, 3'h6, 10'h070);
    act_all(1'b0);
  endtask
  task automatic summarize();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    // A real falling edge on reset is needed: the link-side flops only see the clock's falling edge,
    // and the host holds that clock high, so without this edge the link state would never leave unknown.
    #1 i_rst_n = 1'b0;
    tick(4);
    i_rst_n = 1'b1;
    tick(2);
    t_global();
    t_channel();
    t_data();
    t_parallel();
    summarize();
  end
  initial begin
    #500000;
    fails++;
    summarize();
  end
endmodule
bind mdc_dac_control mdc_dac_control_monitor #(.OCTAL(OCTAL)) i_mdc_dac_control_monitor (.i_clock(i_clock),
  .i_rst_n(i_rst_n), .i_shift_clock(i_shift_clock), .i_frame_sync_n(i_frame_sync_n),
  .i_serial_data_in(i_serial_data_in), .i_par(i_par), .i_load_outputs_n(i_load_outputs_n), .i_clear_n(i_clear_n),
  .o_channels(o_channels), .o_ref_enable(o_ref_enable), .o_coding_select(o_coding_select));
